// *** design/battery_presence_detector.sv ***
// Purpose: battery presence sequencer with AHB-Lite registers
// Assumes: comparator flags asynchronous; all else synchronous to clock
// Notes: window lengths are parameters so simulation can shorten them
// How it works
// - after power-up turn on 8 mA sink and start 1 s window
// - below low threshold within 1 s: sink off, 125 mA charge on
// - above recharge threshold within 500 ms: absent, restart sequence
// - either window expiring first: battery present, start normal charge
// - charge-permit falling edge resets timers, restarts the sequence and latches a permit-drop event
// - while battery absent both status lines stay off
`timescale 1ns/100ps
`include "batt_detect_consts.svh"
module battery_presence_detector #(
  parameter logic [`CNT_W-1:0] DISCH_CYCLES = `CNT_W'(`DISCH_CYCLES),
  parameter logic [`CNT_W-1:0] LOWCUR_CYCLES = `CNT_W'(`LOWCUR_CYCLES)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // analog comparator flags, charge permit and charge done
  input wire logic belowLowVoltage,
  input wire logic aboveRecharge,
  input wire logic chargePermit,
  input wire logic chargeDone,
  // drives toward the analog section
  output batt_detect_pkg::drive_t drive,
  // open-drain status lines, enable high turns the transistor on
  output logic statusLineAOut,
  output logic statusLineAOe,
  output logic statusLineBOut,
  output logic statusLineBOe,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // interrupt
  output logic irq
);
  batt_detect_pkg::seq_state_t state_r, state_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  logic lowMeta_r, lowSync_r, highMeta_r, highSync_r;
  logic permit_r;
  logic restart_r;
  logic [`IRQ_W-1:0] irqStat_r, irqMask_r;
  logic wrPend_r;
  logic [`ADDR_DEC_W-1:0] wrAddr_r;
  logic [31:0] hrdata_r;
  batt_detect_pkg::drive_t drive_r;
  batt_detect_pkg::status_t stat_r;

  // comparator synchronisers: the flags move with the analog node, not
  // with the clock, so only the second flop is ever read by the sequencer
  always_ff @(posedge clock) begin
    lowMeta_r <= belowLowVoltage;
    lowSync_r <= lowMeta_r;
    highMeta_r <= aboveRecharge;
    highSync_r <= highMeta_r;
  end

  // permit_r resets low so a permit already low gives no false edge
  wire permitFall = permit_r & ~chargePermit;
  wire discWinEnd = (cnt_r == DISCH_CYCLES - `CNT_W'(1));
  wire lowWinEnd = (cnt_r == LOWCUR_CYCLES - `CNT_W'(1));
  wire inDisc = (state_r == batt_detect_pkg::ST_DISCHARGE);
  wire inLow = (state_r == batt_detect_pkg::ST_LOWCUR);
  wire evPresent = (inDisc & ~lowSync_r & discWinEnd) |
                   (inLow & ~highSync_r & lowWinEnd);
  wire evAbsent = inLow & highSync_r;

  // sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + `CNT_W'(1);
    case (state_r)
      batt_detect_pkg::ST_IDLE: begin
        state_nxt = batt_detect_pkg::ST_DISCHARGE;
        cnt_nxt = '0;
      end
      batt_detect_pkg::ST_DISCHARGE: begin
        if (lowSync_r) begin
          state_nxt = batt_detect_pkg::ST_LOWCUR;
          cnt_nxt = '0;
        end else if (discWinEnd) begin
          state_nxt = batt_detect_pkg::ST_CHARGE;
        end
      end
      batt_detect_pkg::ST_LOWCUR: begin
        if (highSync_r) begin
          state_nxt = batt_detect_pkg::ST_ABSENT;
        end else if (lowWinEnd) begin
          state_nxt = batt_detect_pkg::ST_CHARGE;
        end
      end
      batt_detect_pkg::ST_CHARGE: cnt_nxt = cnt_r;
      batt_detect_pkg::ST_ABSENT: begin
        state_nxt = batt_detect_pkg::ST_DISCHARGE;
        cnt_nxt = '0;
      end
      default: state_nxt = batt_detect_pkg::ST_IDLE;
    endcase
    if (permitFall | restart_r) begin
      state_nxt = batt_detect_pkg::ST_IDLE;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= batt_detect_pkg::ST_IDLE;
      cnt_r <= '0;
      permit_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      permit_r <= chargePermit;
    end
  end

  // next-state decode feeding the registered drives; using the next state
  // lets the drives change on the same edge as the state itself
  wire nxtDisch = (state_nxt == batt_detect_pkg::ST_DISCHARGE);
  wire nxtLow = (state_nxt == batt_detect_pkg::ST_LOWCUR);
  wire nxtCharging = (state_nxt == batt_detect_pkg::ST_CHARGE) & chargePermit;
  // absent or probing: both lines off
  wire lineAOn = nxtCharging & ~chargeDone;
  wire lineBOn = nxtCharging & chargeDone;

  // registered drives and status
  always_ff @(posedge clock) begin
    if (rst) begin
      drive_r <= '0;
      stat_r <= '0;
    end else begin
      drive_r.dischargeSink <= nxtDisch;
      drive_r.lowCurrentCharge <= nxtLow;
      drive_r.normalCharge <= nxtCharging;
      stat_r.statusLineAOn <= lineAOn;
      stat_r.statusLineBOn <= lineBOn;
    end
  end
  assign drive = drive_r;
  assign statusLineAOut = 1'b0;
  assign statusLineAOe = stat_r.statusLineAOn;
  assign statusLineBOut = 1'b0;
  assign statusLineBOe = stat_r.statusLineBOn;

  // AHB-Lite slave: zero wait states, always OKAY
  wire addrPhase = hsel & hready & (htrans == `HTRANS_NONSEQ);
  wire [`ADDR_DEC_W-1:0] rdSel = haddr[`ADDR_DEC_W-1:0];
  wire wrCtrl = wrPend_r & (wrAddr_r == `ADDR_DEC_W'(`ADDR_CTRL));
  wire wrStat = wrPend_r & (wrAddr_r == `ADDR_DEC_W'(`ADDR_IRQ_STAT));
  wire wrMask = wrPend_r & (wrAddr_r == `ADDR_DEC_W'(`ADDR_IRQ_MASK));
  wire [`IRQ_W-1:0] evVec = {permitFall, evAbsent, evPresent};
  wire [31:0] statusWord = {27'h0, state_r};

  // read decode; the control word and unmapped offsets read as zero
  wire selStatus = (rdSel == `ADDR_DEC_W'(`ADDR_STATUS));
  wire selIrqStat = (rdSel == `ADDR_DEC_W'(`ADDR_IRQ_STAT));
  wire selIrqMask = (rdSel == `ADDR_DEC_W'(`ADDR_IRQ_MASK));
  wire [31:0] irqStatWord = {29'h0, irqStat_r};
  wire [31:0] irqMaskWord = {29'h0, irqMask_r};
  wire [31:0] rdWord =
    selStatus ? statusWord :
    selIrqStat ? irqStatWord :
    selIrqMask ? irqMaskWord :
    32'h0000_0000;

  // bus strobes; write data only stands in the data phase, one cycle later
  wire rdStart = addrPhase & ~hwrite;
  wire wrStart = addrPhase & hwrite;
  wire restartReq = wrCtrl & hwdata[0];

  always_ff @(posedge clock) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      hrdata_r <= '0;
      restart_r <= `CTRL_RESET;
    end else begin
      wrPend_r <= wrStart;
      wrAddr_r <= haddr[`ADDR_DEC_W-1:0];
      hrdata_r <= rdStart ? rdWord : hrdata_r;
      restart_r <= restartReq;
    end
  end

  // sticky events, write one to clear; a new event wins over the clear
  // so an event landing on the clear cycle is never lost
  wire [`IRQ_W-1:0] clrVec = wrStat ? hwdata[`IRQ_W-1:0] : '0;
  wire [`IRQ_W-1:0] irqStat_nxt = (irqStat_r & ~clrVec) | evVec;
  wire [`IRQ_W-1:0] irqMask_nxt = wrMask ? hwdata[`IRQ_W-1:0] : irqMask_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      irqStat_r <= `IRQ_RESET;
      irqMask_r <= `IRQ_RESET;
    end else begin
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
    end
  end

  // zero wait states: every transfer completes in its data phase

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(irqStat_r & irqMask_r);
endmodule // battery_presence_detector

// *** inc/batt_detect_consts.svh ***
// Purpose: named constants for the battery presence detector
// Assumes: 100 MHz system clock
// Notes: byte addresses are word aligned
`ifndef BATT_DETECT_CONSTS_SVH
`define BATT_DETECT_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define DISCH_WINDOW_MS 1000
`define LOWCUR_WINDOW_MS 500
`define DISCH_CYCLES ((`DISCH_WINDOW_MS * 1000000) / `CLK_PERIOD_NS)
`define LOWCUR_CYCLES ((`LOWCUR_WINDOW_MS * 1000000) / `CLK_PERIOD_NS)
`define CNT_W 27
`define ADDR_CTRL 32'h0000_0000
`define ADDR_STATUS 32'h0000_0004
`define ADDR_IRQ_STAT 32'h0000_0008
`define ADDR_IRQ_MASK 32'h0000_000c
`define ADDR_DEC_W 4
`define CTRL_RESET 1'h0
`define IRQ_W 3
`define IRQ_RESET 3'h0
`define IRQ_BIT_PRESENT 0
`define IRQ_BIT_ABSENT 1
`define IRQ_BIT_PERMIT_DROP 2
`define HTRANS_NONSEQ 2'h2
`endif

// *** inc/batt_detect_pkg.sv ***
// Purpose: types for the battery presence detector
// Assumes: nothing
// Notes: one-hot sequencer states
package batt_detect_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DISCHARGE = 5'h02,
    ST_LOWCUR = 5'h04,
    ST_CHARGE = 5'h08,
    ST_ABSENT = 5'h10
  } seq_state_t;
  typedef struct packed {
    logic dischargeSink;
    logic lowCurrentCharge;
    logic normalCharge;
  } drive_t;
  typedef struct packed {
    logic statusLineAOn;
    logic statusLineBOn;
  } status_t;
endpackage

// *** verif/batt_pack_model.sv ***
// Purpose: battery node as seen through the two comparators
// Assumes: sink and charge requests come from the detector drive
// Notes: nodeHolds = charged pack, nodeRises = bare output capacitor
`timescale 1ns/100ps
module batt_pack_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // node drive and pack kind
  input batt_detect_pkg::drive_t drive,
  input wire logic nodeHolds,
  input wire logic nodeRises,
  // comparator flags
  output logic belowLowVoltage,
  output logic aboveRecharge
);
  logic [3:0] sinkCnt_r;
  logic [3:0] chgCnt_r;
  always_ff @(posedge clock) begin
    sinkCnt_r <= drive.dischargeSink && !rst ?
      sinkCnt_r + 4'(sinkCnt_r != 4'hf) : 4'h0;
    chgCnt_r <= drive.lowCurrentCharge && !rst ?
      chgCnt_r + 4'(chgCnt_r != 4'hf) : 4'h0;
  end
  // node voltage follows the sink or the small charge current
  assign belowLowVoltage = !nodeHolds && sinkCnt_r >= 4'h5;
  assign aboveRecharge = nodeRises && chgCnt_r >= 4'h3;
endmodule // batt_pack_model

// *** verif/battery_presence_detector_chk.sv ***
// Purpose: timing checks on the presence sequencer ports
// Assumes: one clock, synchronous active high reset
// Notes: discharge window shortened through DISCH_CYCLES
`timescale 1ns/100ps
`include "batt_detect_consts.svh"
module battery_presence_detector_chk #(
  parameter logic [`CNT_W-1:0] DISCH_CYCLES = 27'd20
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched ports
  input wire logic belowLowVoltage,
  input wire logic chargePermit,
  input batt_detect_pkg::drive_t drive,
  input wire logic statusLineAOut,
  input wire logic statusLineAOe,
  input wire logic statusLineBOut,
  input wire logic statusLineBOe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff rst;
  logic [`CNT_W-1:0] sinkLen_r;
  always_ff @(posedge clock)
    sinkLen_r <= (rst || !drive.dischargeSink) ? '0 : sinkLen_r + 1'b1;
  a_sink_after_reset: assert property ($fell(rst) |-> ##[1:3]
    drive.dischargeSink) else $error("sink not on after reset");
  a_low_to_lowcur: assert property ($rose(belowLowVoltage) &&
    drive.dischargeSink |-> ##[1:5] (drive.lowCurrentCharge &&
    !drive.dischargeSink)) else $error("no low current step");
  a_absent_restart: assert property ($fell(drive.lowCurrentCharge) &&
    !drive.normalCharge |-> ##[1:4] drive.dischargeSink)
    else $error("no restart after absent");
  a_expire_present: assert property ($fell(drive.dischargeSink) &&
    !drive.lowCurrentCharge && chargePermit |-> drive.normalCharge)
    else $error("no charge after window");
  a_permit_restart: assert property ($fell(chargePermit) |->
    ##[1:6] drive.dischargeSink) else $error("permit drop ignored");
  a_status_off: assert property (!drive.normalCharge [*2] |->
    !statusLineAOe && !statusLineBOe) else $error("status on idle");
  a_od_lines_low: assert property (!statusLineAOut &&
    !statusLineBOut) else $error("status line driven high");
  a_disch_window: assert property (sinkLen_r <= DISCH_CYCLES + 1)
    else $error("discharge window too long");
  c_deep: cover property ($fell(drive.lowCurrentCharge) && drive.normalCharge);
  c_permit: cover property ($fell(chargePermit));
  c_charge: cover property ($rose(drive.normalCharge));
endmodule // battery_presence_detector_chk
bind battery_presence_detector battery_presence_detector_chk #(
  .DISCH_CYCLES(DISCH_CYCLES)) chk_i (.clock, .rst, .belowLowVoltage,
  .chargePermit, .drive, .statusLineAOut, .statusLineAOe, .statusLineBOut,
  .statusLineBOe);

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the presence sequencer
// Assumes: shortened windows of 20 and 10 cycles
// Notes: hready is the slave's own hreadyout
`timescale 1ns/100ps
`include "batt_detect_consts.svh"
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic chargePermit = 1'b1;
  logic chargeDone = 1'b0;
  logic nodeHolds = 1'b0;
  logic nodeRises = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic belowLowVoltage, aboveRecharge, hreadyout, hresp, irq;
  logic statusLineAOut, statusLineAOe, statusLineBOut, statusLineBOe;
  batt_detect_pkg::drive_t drive;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 clock = ~clock;
  battery_presence_detector #(.DISCH_CYCLES(27'd20), .LOWCUR_CYCLES(27'd10))
  dut (.clock, .rst, .belowLowVoltage, .aboveRecharge, .chargePermit,
    .chargeDone, .drive, .statusLineAOut, .statusLineAOe, .statusLineBOut,
    .statusLineBOe, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq);
  batt_pack_model pack (.clock, .rst, .drive, .nodeHolds, .nodeRises,
    .belowLowVoltage, .aboveRecharge);
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, d);
    htrans <= `HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_bit(input int idx, input int lim);
    for (int i = 0; i < lim && drive[idx] !== 1'b1; i++) @(posedge clock);
  endtask
  task automatic t_absent;
    wait_bit(1, 40);
    chk("sink", 0, drive.dischargeSink);
    chk("lineA", 0, statusLineAOe);
    chk("lineB", 0, statusLineBOe);
    wait_bit(2, 20);
    chk("restart", 1, drive.dischargeSink);
    nodeHolds <= 1'b1;
    $display("absent test done");
  endtask
  task automatic t_present;
    wait_bit(0, 40);
    chk("normalCharge", 1, drive.normalCharge);
    bus(0, `ADDR_STATUS, 0);
    chk("state", 32'h8, rd);
    bus(0, `ADDR_IRQ_STAT, 0);
    chk("events", 32'h3, rd);
    bus(0, `ADDR_CTRL, 0);
    chk("ctrl", 32'h0, rd);
    bus(1, `ADDR_IRQ_MASK, 32'h2);
    @(posedge clock);
    chk("irq", 1, irq);
    bus(1, `ADDR_IRQ_STAT, 32'h2);
    @(posedge clock);
    chk("irq", 0, irq);
    chk("lineA", 1, statusLineAOe);
    chk("hresp", 0, hresp);
    chargeDone <= 1'b1;
    repeat (2) @(posedge clock);
    chk("lineB", 1, statusLineBOe);
    chk("lineA", 0, statusLineAOe);
    chargeDone <= 1'b0;
    $display("present test done");
  endtask
  task automatic t_permit;
    chargePermit <= 1'b0;
    @(posedge clock);
    wait_bit(2, 10);
    chk("sink", 1, drive.dischargeSink);
    chargePermit <= 1'b1;
    bus(0, `ADDR_IRQ_STAT, 0);
    chk("events", 32'h5, rd);
    $display("permit test done");
  endtask
  task automatic t_deep;
    wait_bit(0, 40);
    nodeHolds <= 1'b0;
    nodeRises <= 1'b0;
    bus(1, `ADDR_CTRL, 32'h1);
    wait_bit(1, 40);
    chk("lowCur", 1, drive.lowCurrentCharge);
    wait_bit(0, 30);
    chk("normalCharge", 1, drive.normalCharge);
    $display("deep test done");
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_absent;
    t_present;
    t_permit;
    t_deep;
    give_verdict;
  end
endmodule // testbench
